/* File: cmrc_regs.svh */
// Purpose: timing constants for the clocked mask rom read controller
// Assumes: system clock of 10 MHz, period 100 ns
// Notes: times in ns, counts derived by rounding as each limit needs
`ifndef CMRC_REGS_SVH
`define CMRC_REGS_SVH
`define CMRC_CLK_PERIOD_NS 100
// every time but the setup rounds up to whole cycles, least and longest alike, never below one cycle
`define CMRC_PRECHARGE_HIGH_TIME_NS 150
`define CMRC_ADDRESS_SETUP_BEFORE_STROBE_NS 0
`define CMRC_ADDRESS_HOLD_AFTER_STROBE_NS 50
`define CMRC_ACCESS_TIME_NS 300
`define CMRC_STROBE_LOW_WIDTH_NS 300
`define CMRC_STROBE_PERIOD_NS 450
`define CMRC_OUTPUT_FLOAT_DELAY_NS 150
// pin to readable byte: catch edge, three stages, clean refresh
`define CMRC_SYNC_CYC 5
`define CMRC_CEIL_CYC(t) (((t) + `CMRC_CLK_PERIOD_NS - 1) / `CMRC_CLK_PERIOD_NS)
`define CMRC_MAX1(v) (((v) < 1) ? 1 : (v))
`define CMRC_PRECHARGE_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_PRECHARGE_HIGH_TIME_NS))
`define CMRC_HOLD_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_ADDRESS_HOLD_AFTER_STROBE_NS))
`define CMRC_ACCESS_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_ACCESS_TIME_NS))
`define CMRC_LOW_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_STROBE_LOW_WIDTH_NS))
`define CMRC_PERIOD_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_STROBE_PERIOD_NS))
`define CMRC_FLOAT_CYC `CMRC_MAX1(`CMRC_CEIL_CYC(`CMRC_OUTPUT_FLOAT_DELAY_NS))
`define CMRC_CNT_W 4
`endif

/* File: cmrc_pkg.sv */
// Purpose: types for the clocked mask rom read controller
// Assumes: nothing beyond the timing header
// Notes: states of the strobe sequencer
package cmrc_pkg;
    typedef enum logic [2:0]
    {
        CMRC_IDLE,
        CMRC_PRECHARGE,
        CMRC_LOW_HOLD,
        CMRC_LOW_WAIT,
        CMRC_RELEASE
    } cmrc_state_e;
endpackage

/* File: cmrc_sync_if.sv */
// Purpose: carries raw pin data into the synchroniser and clean data out
// Assumes: one clock domain
// Notes: modports for the producer and the synchroniser
`timescale 1ns/1ps
`default_nettype none
interface cmrc_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;   // straight from the pins
    logic [W-1:0] clean; // settled value
    logic [W-1:0] agree; // second and third stage agree per bit
    modport top (output raw, input clean, input agree);
    modport sync (input raw, output clean, output agree);
endinterface
`default_nettype wire

/* File: cmrc_pin_sync.sv */
// Purpose: three-stage synchroniser for the rom data pins
// Assumes: pins may change at any time
// Notes: a bit counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cmrc_pin_sync
    import cmrc_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic CLK,
    input wire logic RST_N,
    cmrc_sync_if.sync s
);
    // ----------------------------------------
    // synchroniser stages
    // ----------------------------------------
    logic [W-1:0] st1_q; // first stage, read only by st2
    logic [W-1:0] st2_q; // second stage
    logic [W-1:0] st3_q; // third stage
    logic [W-1:0] clean_q; // accepted value

    // three flops per bit, then accept where stages agree
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st1_q <= '0;
            st2_q <= '0;
            st3_q <= '0;
        end
        else
        begin
            st1_q <= s.raw;
            st2_q <= st1_q;
            st3_q <= st2_q;
        end
    end

    // per bit acceptance, generated
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                    clean_q[i] <= 1'b0;
                else if (st2_q[i] == st3_q[i])
                    clean_q[i] <= st3_q[i];
            end
        end
    endgenerate

    assign s.clean = clean_q;
    assign s.agree = ~(st2_q ^ st3_q);
endmodule
`default_nettype wire

/* File: cmrc_host.sv */
// Purpose: host controller reading a clocked mask rom through its pins
// Assumes: 10 MHz CLK; the rom drives data within its access time
// Notes: one read per request; strobe timing kept by cycle counters
`timescale 1ns/1ps
`default_nettype none
`include "cmrc_regs.svh"
module cmrc_host
    import cmrc_pkg::*;
#(
    parameter int AW = 13,
    parameter int DW = 8
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic [AW-1:0] REQ_ADDR,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [DW-1:0] RSP_DATA,
    output logic ROM_STROBE_N,
    output logic [AW-1:0] ROM_ADDR,
    input wire logic [DW-1:0] ROM_DATA
);
    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam logic [`CMRC_CNT_W-1:0] PRE_CYC = `CMRC_CNT_W'(`CMRC_PRECHARGE_CYC);
    localparam logic [`CMRC_CNT_W-1:0] HOLD_CYC = `CMRC_CNT_W'(`CMRC_HOLD_CYC);
    localparam logic [`CMRC_CNT_W-1:0] ACC_CYC = `CMRC_CNT_W'(`CMRC_ACCESS_CYC);
    localparam logic [`CMRC_CNT_W-1:0] LOW_CYC = `CMRC_CNT_W'(`CMRC_LOW_CYC);
    localparam logic [`CMRC_CNT_W-1:0] PER_CYC = `CMRC_CNT_W'(`CMRC_PERIOD_CYC);
    localparam logic [`CMRC_CNT_W-1:0] FLT_CYC = `CMRC_CNT_W'(`CMRC_FLOAT_CYC);
    // cycles from a settled pin to a byte that the capture can read:
    // one edge to catch the pin, three stages, one to refresh clean;
    // an access that ends right on an edge is caught only at the next
    localparam logic [`CMRC_CNT_W-1:0] SYNC_CYC = `CMRC_CNT_W'(`CMRC_SYNC_CYC);
    // strobe stays low until both the width and the synced data are met
    localparam logic [`CMRC_CNT_W-1:0] LOWEND_CYC =
        (LOW_CYC > ACC_CYC + SYNC_CYC) ? LOW_CYC : ACC_CYC + SYNC_CYC;

    // ----------------------------------------
    // state
    // ----------------------------------------
    cmrc_state_e state_q; // sequencer state
    logic [`CMRC_CNT_W-1:0] low_cnt_q; // cycles since strobe fell
    logic [`CMRC_CNT_W-1:0] high_cnt_q; // cycles since strobe rose
    logic [`CMRC_CNT_W-1:0] per_cnt_q; // cycles since last fall
    logic strobe_n_q; // strobe pin
    logic [AW-1:0] addr_q; // address pins
    logic [DW-1:0] data_q; // captured byte
    logic rsp_q; // response pulse
    logic take; // request accepted at this edge
    logic rise_now; // strobe rises at this edge

    cmrc_sync_if #(.W(DW)) dsync ();

    assign dsync.raw = ROM_DATA;

    cmrc_pin_sync #(.W(DW)) u_sync
    (
        .CLK(CLK),
        .RST_N(RST_N),
        .s(dsync.sync)
    );

    // next falling edge allowed only after precharge and period
    function automatic logic may_fall(input logic [`CMRC_CNT_W-1:0] hi,
                                      input logic [`CMRC_CNT_W-1:0] per);
        may_fall = (hi >= PRE_CYC) && (per >= PER_CYC);
    endfunction

    // request taken only when the strobe may fall this edge
    assign REQ_READY = (state_q == CMRC_IDLE)
        && may_fall(high_cnt_q, per_cnt_q);

    // last low cycle: width, access time and synchroniser margin all met
    function automatic logic low_done(input cmrc_state_e st,
                                      input logic [`CMRC_CNT_W-1:0] cnt);
        low_done = (st == CMRC_LOW_WAIT) && (cnt + 1'b1 >= LOWEND_CYC);
    endfunction

    // accept decode, shared by sequencer, strobe, address and spacing
    assign take = (state_q == CMRC_IDLE) && REQ_VALID && REQ_READY;

    // rise decode, shared by sequencer, strobe and capture
    assign rise_now = low_done(state_q, low_cnt_q);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            state_q <= CMRC_IDLE;
        else
        begin
            case (state_q)
                CMRC_IDLE: // strobe high, rom in standby
                    // a take moves straight into the low phase
                    if (take)
                        state_q <= CMRC_LOW_HOLD;
                CMRC_LOW_HOLD: // address must stay put
                    if (low_cnt_q + 1'b1 >= HOLD_CYC)
                        state_q <= CMRC_LOW_WAIT;
                CMRC_LOW_WAIT: // wait for width and data
                    if (rise_now)
                        state_q <= CMRC_RELEASE;
                CMRC_RELEASE: // strobe high, rom floats its pins
                    state_q <= CMRC_PRECHARGE;
                CMRC_PRECHARGE:
                    if (high_cnt_q + 1'b1 >= FLT_CYC)
                        state_q <= CMRC_IDLE;
                default:
                    state_q <= CMRC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // strobe and address pins
    // ----------------------------------------
    // strobe falls on the same edge that sets the address, rises at release
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            strobe_n_q <= 1'b1;
        else if (take)
            strobe_n_q <= 1'b0;
        // no rise before the synchronised byte is readable
        else if (rise_now)
            strobe_n_q <= 1'b1;
    end

    // address set on the same edge as the fall: zero setup is enough
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            addr_q <= '0;
        // address only moves at a take, so it holds the whole low phase
        else if (take)
            addr_q <= REQ_ADDR;
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    // low time since the fall
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            low_cnt_q <= '0;
        else if (strobe_n_q)
            low_cnt_q <= '0;
        else if (low_cnt_q != '1)
            low_cnt_q <= low_cnt_q + 1'b1;
    end

    // high time since the rise, starts satisfied after reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            high_cnt_q <= PRE_CYC;
        else if (!strobe_n_q)
            high_cnt_q <= '0;
        else if (high_cnt_q != '1)
            high_cnt_q <= high_cnt_q + 1'b1;
    end

    // fall to fall spacing
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            per_cnt_q <= PER_CYC;
        // every fall restarts the spacing count
        else if (take)
            per_cnt_q <= '0;
        else if (per_cnt_q != '1)
            per_cnt_q <= per_cnt_q + 1'b1;
    end

    // ----------------------------------------
    // data capture
    // ----------------------------------------
    // sample while the rom still drives, just before the rise
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            data_q <= '0;
            rsp_q <= 1'b0;
        end
        // clean lags the pins; rise_now already allows for that lag
        else if (rise_now)
        begin
            data_q <= dsync.clean;
            rsp_q <= 1'b1;
        end
        else
            rsp_q <= 1'b0;
    end

    assign ROM_STROBE_N = strobe_n_q;
    assign ROM_ADDR = addr_q;
    assign RSP_DATA = data_q;
    assign RSP_VALID = rsp_q;
endmodule
`default_nettype wire

/* File: cmrc_rom_model.sv */
// Purpose: behavioural clocked rom that stands on the far side of the host
// Assumes: strobe is the only timing input; no free clock
// Notes: slow selects the longest access time, else a quick one
`timescale 1ns/1ps
`default_nettype none
module cmrc_rom_model
(
    input wire logic strobe_n,
    input wire logic [12:0] addr,
    input wire logic slow,
    output logic [7:0] data
);
    logic [12:0] held_addr; // address caught at the fall
    logic [7:0] word; // last byte presented
    initial
    begin
        data = 8'hA5;
        word = 8'h5A;
    end
    // fall: latch address, garbage until the access time is over
    always @(negedge strobe_n)
    begin
        held_addr = addr;
        data = ~data;
        #(slow ? 300 : 100);
        word = held_addr[7:0] ^ {3'h0, held_addr[12:8]};
        if (!strobe_n)
            data = word;
    end
    // rise: standby, floating bus shows the inverse of the last byte
    always @(posedge strobe_n)
        #150 data = ~word;
endmodule
`default_nettype wire

/* File: cmrc_host_sva.sv */
// Purpose: port-level checks on the rom read controller
// Assumes: one clock, synchronous active-low reset
// Notes: cycle figures follow the strobe walk of the host
`timescale 1ns/1ps
`default_nettype none
module cmrc_host_sva
#(
    parameter int AW = 13,
    parameter int DW = 8
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic [AW-1:0] REQ_ADDR,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic [DW-1:0] RSP_DATA,
    input wire logic ROM_STROBE_N,
    input wire logic [AW-1:0] ROM_ADDR,
    input wire logic [DW-1:0] ROM_DATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_take_falls:
        assert property (REQ_VALID && REQ_READY |=> $fell(ROM_STROBE_N))
        else $error("strobe did not fall after a take");
    a_addr_caught:
        assert property (REQ_VALID && REQ_READY |=> ROM_ADDR == $past(REQ_ADDR))
        else $error("rom address differs from request");
    a_low_width:
        assert property ($fell(ROM_STROBE_N) |-> !ROM_STROBE_N [*8] ##1 ROM_STROBE_N)
        else $error("strobe low time wrong");
    a_addr_hold:
        assert property (!ROM_STROBE_N && !$past(ROM_STROBE_N) |-> $stable(ROM_ADDR))
        else $error("address moved while strobe low");
    a_rsp_on_rise:
        assert property (RSP_VALID == $rose(ROM_STROBE_N))
        else $error("response not tied to strobe rise");
    a_rsp_pulse:
        assert property (RSP_VALID |=> !RSP_VALID)
        else $error("response longer than one cycle");
    a_data_holds:
        assert property (!RSP_VALID |-> $stable(RSP_DATA))
        else $error("response byte changed without response");
    a_precharge:
        assert property ($rose(ROM_STROBE_N) |-> ROM_STROBE_N [*2])
        else $error("strobe high time too short");
    a_fall_spacing:
        assert property ($fell(ROM_STROBE_N) |-> !REQ_READY [*8])
        else $error("ready came back too early");
    c_take: cover property (REQ_VALID && REQ_READY);
    c_refused: cover property (REQ_VALID && !REQ_READY);
    c_resp: cover property (RSP_VALID);
endmodule
bind cmrc_host cmrc_host_sva #(.AW(AW), .DW(DW)) u_sva
(
    .CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .ROM_STROBE_N(ROM_STROBE_N), .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA)
);
`default_nettype wire

/* File: cmrc_host_bench.sv */
// Purpose: self-checking bench for the rom read controller
// Assumes: inputs change at the falling clock edge
// Notes: each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none
module cmrc_host_bench;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic REQ_VALID = 1'b0;
    logic [12:0] REQ_ADDR = 13'h0000;
    logic slow = 1'b0; // picks the longest rom access
    logic REQ_READY, RSP_VALID, ROM_STROBE_N;
    logic [7:0] RSP_DATA, ROM_DATA;
    logic [12:0] ROM_ADDR;
    int bad_count = 0;
    int checks_done = 0;
    time t_take; // moment just after the last take
    always #50 CLK = ~CLK;
    cmrc_host dut (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR),
        .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
        .ROM_STROBE_N(ROM_STROBE_N), .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA));
    cmrc_rom_model rom (.strobe_n(ROM_STROBE_N), .addr(ROM_ADDR), .slow(slow), .data(ROM_DATA));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic logic [7:0] word_of(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // one read; request moves on right after the take
    task automatic read_word(input logic [12:0] a);
        int n;
        n = 0;
        REQ_VALID = 1'b1;
        REQ_ADDR = a;
        while (REQ_READY !== 1'b1 && n < 20)
        begin
            @(negedge CLK);
            n++;
        end
        @(negedge CLK);
        t_take = $time;
        REQ_VALID = 1'b0;
        REQ_ADDR = ~a;
        n = 1;
        while (RSP_VALID !== 1'b1 && n < 20)
        begin
            if (ROM_STROBE_N === 1'b0)
                chk(ROM_ADDR === a, "address moved mid read");
            @(negedge CLK);
            n++;
        end
        chk(n == 9, "response latency");
        chk(RSP_DATA === word_of(a), "read byte");
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset;
        chk(ROM_STROBE_N === 1'b1 && RSP_VALID === 1'b0, "idle after reset");
        chk(RSP_DATA === 8'h00 && ROM_ADDR === 13'h0000, "cleared outputs");
        chk(REQ_READY === 1'b1, "ready at first edge");
    endtask
    task automatic t_bounds;
        logic [12:0] list [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
        foreach (list[i])
            read_word(list[i]);
    endtask
    task automatic t_slow;
        slow = 1'b1;
        read_word(13'h1234);
        slow = 1'b0;
    endtask
    // second request raised at once, must wait out the spacing
    task automatic t_spacing;
        time t0;
        read_word(13'h0F0F);
        t0 = t_take;
        read_word(13'h10F0);
        chk(t_take - t0 >= 1000, "takes too close");
    endtask
    // reset lands while the strobe is low, then a clean read follows
    task automatic t_mid_reset;
        int n;
        n = 0;
        REQ_VALID = 1'b1;
        REQ_ADDR = 13'h0333;
        while (REQ_READY !== 1'b1 && n < 20)
        begin
            @(negedge CLK);
            n++;
        end
        @(negedge CLK);
        REQ_VALID = 1'b0;
        @(negedge CLK);
        chk(ROM_STROBE_N === 1'b0, "strobe low mid read");
        RST_N = 1'b0;
        repeat (3) @(negedge CLK);
        chk(ROM_STROBE_N === 1'b1 && RSP_VALID === 1'b0, "idle after mid reset");
        chk(ROM_ADDR === 13'h0000 && RSP_DATA === 8'h00, "cleared by mid reset");
        chk(REQ_READY === 1'b1, "ready after mid reset");
        RST_N = 1'b1;
        read_word(13'h0333);
    endtask
    initial
    begin
        repeat (3) @(negedge CLK);
        RST_N = 1'b1;
        t_reset();
        t_bounds();
        t_slow();
        t_spacing();
        t_mid_reset();
        print_verdict();
    end
    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        #300000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
